// ### bench/cpu_ctl_props.sv
// checker properties for the control and time base block
`timescale 1ns/10ps
`default_nettype none
`include "cpu_ctl_cfg.svh"
module cpu_ctl_props #(
	parameter int AW = 32
) (
	// clock and reset
	input wire logic                    i_clk,
	input wire logic                    i_arst_n,
	// watched ports
	input wire cpu_ctl_pkg::spr_req_t   i_spr_req,
	input wire logic                    o_spr_ack,
	input wire logic                    o_spr_illegal,
	input wire logic                    o_spr_priv_fault,
	input wire logic [31:0]             o_msr,
	input wire logic [AW-1:0]           i_addr_bus,
	input wire logic [AW/8-1:0]         o_addr_par,
	input wire logic                    o_exc_take,
	input wire cpu_ctl_pkg::exc_cause_t o_exc_cause,
	input wire logic                    o_handler_start,
	input wire logic [31:0]             o_save_restore_second,
	input wire logic                    o_checkstop,
	input wire logic                    o_fp_exc_enabled,
	input wire logic                    o_fp_precise
);
	// ********
	// helpers
	// ********
	logic [1:0] up_ff;
	logic [1:0] nxt_up;
	logic       num_rd;
	logic       num_wr;
	assign num_rd = i_spr_req.num == `SPR_TB_HIGH_RD || i_spr_req.num == `SPR_TB_LOW_RD;
	assign num_wr = i_spr_req.num == `SPR_TB_HIGH_WR || i_spr_req.num == `SPR_TB_LOW_WR;
	// parity output is stale until the internal reset copy lets go
	always_comb begin
		nxt_up = (up_ff == 2'h3) ? up_ff : up_ff + 2'h1;
	end
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) up_ff <= 2'h0;
		else up_ff <= nxt_up;
	end
	function automatic logic [AW/8-1:0] odd_par(input logic [AW-1:0] v);
		for (int i = 0; i < AW/8; i++) odd_par[i] = ~^v[8*i+:8];
	endfunction
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	// ********
	// properties
	// ********
	a_ack_after_req: assert property (i_spr_req.valid |=> o_spr_ack)
		else $error("no ack after request");
	a_ack_has_req: assert property (o_spr_ack |-> $past(i_spr_req.valid))
		else $error("ack without request");
	a_tb_rd_ok: assert property (i_spr_req.valid && !i_spr_req.write && num_rd
		|=> !o_spr_illegal && !o_spr_priv_fault) else $error("time base read refused");
	a_wr_num_read: assert property (i_spr_req.valid && !i_spr_req.write && num_wr
		|=> o_spr_illegal) else $error("read of write number not illegal");
	a_tb_wr_priv: assert property (i_spr_req.valid && i_spr_req.write
		&& !i_spr_req.supervisor && num_wr |=> o_spr_priv_fault) else $error("user write kept");
	a_ctl_priv: assert property (i_spr_req.valid && !i_spr_req.supervisor
		&& i_spr_req.num == `SPR_IMPL_CTL_ZERO |=> o_spr_priv_fault) else $error("user ctl access");
	a_ext_masked: assert property (o_exc_take && o_exc_cause == cpu_ctl_pkg::CAUSE_EXTERNAL
		|-> $past(o_msr[15])) else $error("external taken while masked");
	a_fp_gated: assert property (o_exc_take && o_exc_cause == cpu_ctl_pkg::CAUSE_FP
		|-> $past(o_fp_exc_enabled)) else $error("fp taken while disabled");
	a_fp_decode: assert property (o_fp_exc_enabled == (o_msr[11] | o_msr[8])
		&& o_fp_precise == o_fp_exc_enabled) else $error("fp mode decode wrong");
	a_save_state: assert property (o_exc_take |-> o_save_restore_second == $past(o_msr))
		else $error("saved state wrong");
	a_handler_next: assert property (o_exc_take |=> o_handler_start ##1 !o_handler_start)
		else $error("handler start missing");
	a_addr_parity: assert property (up_ff == 2'h3 |-> o_addr_par == odd_par($past(i_addr_bus)))
		else $error("address parity wrong");
	a_stop_sticky: assert property (o_checkstop |=> o_checkstop)
		else $error("checkstop dropped");
	c_external: cover property (o_exc_take && o_exc_cause == cpu_ctl_pkg::CAUSE_EXTERNAL);
	c_mchk: cover property (o_exc_take && o_exc_cause == cpu_ctl_pkg::CAUSE_MCHK);
	c_illegal: cover property (o_spr_illegal);
	c_stop: cover property ($rose(o_checkstop));
endmodule
bind cpu_control_time_base_regs cpu_ctl_props #(.AW(AW)) props_u (
	.i_clk, .i_arst_n, .i_spr_req, .o_spr_ack, .o_spr_illegal, .o_spr_priv_fault, .o_msr,
	.i_addr_bus, .o_addr_par, .o_exc_take, .o_exc_cause, .o_handler_start,
	.o_save_restore_second, .o_checkstop, .o_fp_exc_enabled, .o_fp_precise
);
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the control and time base block
`timescale 1ns/10ps
`default_nettype none
`include "cpu_ctl_cfg.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
	$display("unexpected at %0t: got %h want %h", $time, a, e); end end
module testbench;
	// ********
	// signals
	// ********
	logic                     i_clk, i_arst_n, i_msr_we, i_tb_tick, i_handler_done;
	logic                     i_machine_check_input_n, i_hard_reset_input_n;
	logic                     i_addr_par_err, i_data_par_err;
	cpu_ctl_pkg::spr_req_t    i_spr_req;
	cpu_ctl_pkg::exc_events_t i_events;
	logic [31:0]              i_msr_wdata, i_addr_bus, o_spr_rdata, o_msr, o_save_restore_second;
	logic [63:0]              i_data_bus;
	logic                     o_spr_ack, o_spr_illegal, o_spr_priv_fault, o_exc_take;
	logic                     o_handler_start, o_checkstop, o_fp_exc_enabled, o_fp_precise;
	logic                     o_clkout_oe, o_clkout_bus_type, ack, ill, prv;
	cpu_ctl_pkg::exc_cause_t  o_exc_cause;
	logic [3:0]               o_addr_par;
	logic [7:0]               o_data_par, e;
	logic [31:0]              rd, hi, lo, m;
	int                       miscompares, checked;
	integer                   seed;
	cpu_control_time_base_regs DUT (.i_clk, .i_arst_n, .i_spr_req, .o_spr_ack, .o_spr_rdata,
		.o_spr_illegal, .o_spr_priv_fault, .i_msr_we, .i_msr_wdata, .o_msr, .i_events,
		.i_tb_tick, .i_handler_done, .i_machine_check_input_n, .i_hard_reset_input_n,
		.i_addr_par_err, .i_data_par_err, .o_exc_take, .o_exc_cause, .o_handler_start,
		.o_save_restore_second, .o_checkstop, .o_fp_exc_enabled, .o_fp_precise,
		.i_addr_bus, .i_data_bus, .o_addr_par, .o_data_par, .o_clkout_oe, .o_clkout_bus_type);
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	// ********
	// tasks
	// ********
	function automatic logic [7:0] par8(input logic [63:0] v);
		for (int i = 0; i < 8; i++) par8[i] = ~^v[8*i+:8];
	endfunction
	task automatic end_of_test();
		$display("miscompares %0d checked %0d", miscompares, checked);
		if (miscompares == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic step();
		@(posedge i_clk);
		#1;
	endtask
	task automatic spr(input logic wr, input logic sup, input logic [9:0] n, input logic [31:0] w);
		step();
		i_spr_req = '{valid: 1'b1, write: wr, supervisor: sup, num: n, wdata: w};
		step();
		i_spr_req.valid = 1'b0;
		{ack, rd, ill, prv} = {o_spr_ack, o_spr_rdata, o_spr_illegal, o_spr_priv_fault};
		`CHK(ack, 1'b1)
	endtask
	task automatic msr_wr(input logic [31:0] v);
		step();
		i_msr_we = 1'b1;
		i_msr_wdata = v;
		step();
		i_msr_we = 1'b0;
	endtask
	// bounded wait; the old state is restored after each handler
	task automatic wait_exc(input logic x, input cpu_ctl_pkg::exc_cause_t c, input logic [31:0] o);
		logic took;
		took = 1'b0;
		for (int n = 0; n < 8 && !took; n++) begin
			if (o_exc_take === 1'b1) begin
				took = 1'b1;
				`CHK(o_exc_cause, c)
				`CHK(o_save_restore_second, o)
				`CHK(o_msr[15], 1'b0)
				step();
				`CHK(o_handler_start, 1'b1)
				i_handler_done = 1'b1;
				step();
				i_handler_done = 1'b0;
				msr_wr(o);
			end else begin
				step();
			end
		end
		`CHK(took, x)
		if (x && !took) end_of_test();
	endtask
	// sources are one-cycle pulses so nothing lingers into the handler
	task automatic fire(input logic [5:0] ev, input logic [2:0] p, input logic x,
		input cpu_ctl_pkg::exc_cause_t c, input logic [31:0] o);
		step();
		i_events = cpu_ctl_pkg::exc_events_t'(ev);
		{i_machine_check_input_n, i_addr_par_err, i_data_par_err} = p ^ 3'h4;
		step();
		i_events = '0;
		{i_machine_check_input_n, i_addr_par_err, i_data_par_err} = 3'h4;
		wait_exc(x, c, o);
	endtask
	initial begin
		#1250000;
		miscompares++;
		end_of_test();
	end
	// ********
	// main sequence
	// ********
	initial begin
		seed = 32'h40766A9A;
		{i_arst_n, i_msr_we, i_msr_wdata, i_tb_tick, i_handler_done} = '0;
		{i_machine_check_input_n, i_hard_reset_input_n, i_addr_par_err, i_data_par_err} = 4'hC;
		{i_spr_req, i_events, i_addr_bus, i_data_bus} = '0;
		{miscompares, checked} = '0;
		repeat (6) @(posedge i_clk);
		#1 i_arst_n = 1'b1;
		repeat (3) step();
		`CHK(o_msr, `MSR_RESET)
		`CHK(o_fp_exc_enabled, 1'b0)
		spr(1'b0, 1'b1, `SPR_IMPL_CTL_ZERO, 32'h0);
		`CHK(rd, `ICZ_RESET)
		for (int k = 0; k < 4; k++) begin
			hi = $random(seed);
			lo = (k == 3) ? 32'hFFFF_FFFF : $random(seed);
			spr(1'b1, 1'b1, `SPR_TB_HIGH_WR, hi);
			spr(1'b1, 1'b1, `SPR_TB_LOW_WR, lo);
			spr(1'b0, k[0], `SPR_TB_HIGH_RD, 32'h0);
			`CHK(rd, hi)
			spr(1'b0, k[0], `SPR_TB_LOW_RD, 32'h0);
			`CHK(rd, lo)
		end
		i_tb_tick = 1'b1;
		step();
		i_tb_tick = 1'b0;
		spr(1'b0, 1'b0, `SPR_TB_LOW_RD, 32'h0);
		`CHK(rd, 32'h0)
		spr(1'b1, 1'b0, `SPR_TB_HIGH_WR, ~hi);
		`CHK(prv, 1'b1)
		wait_exc(1'b1, cpu_ctl_pkg::CAUSE_SPR_ILL, 32'h0);
		spr(1'b0, 1'b1, `SPR_TB_HIGH_RD, 32'h0);
		`CHK(rd, hi + 32'h1)
		for (int k = 0; k < 2; k++) begin
			spr(1'b0, 1'b1, 10'(`SPR_TB_HIGH_WR + k), 32'h0);
			`CHK(ill, 1'b1)
			wait_exc(1'b1, cpu_ctl_pkg::CAUSE_SPR_ILL, 32'h0);
		end
		spr(1'b0, 1'b0, `SPR_IMPL_CTL_ZERO, 32'h0);
		`CHK(prv, 1'b1)
		wait_exc(1'b1, cpu_ctl_pkg::CAUSE_SPR_ILL, 32'h0);
		for (int k = 0; k < 5; k++) begin
			msr_wr(32'h0);
			fire(6'h20 >> k, 3'h0, 1'b0, cpu_ctl_pkg::CAUSE_NONE, 32'h0);
			msr_wr(32'h0000_8000);
			fire(6'h20 >> k, 3'h0, 1'b1, cpu_ctl_pkg::CAUSE_EXTERNAL, 32'h0000_8000);
		end
		for (int k = 0; k < 4; k++) begin
			m = (32'(k[1]) << 11) | (32'(k[0]) << 8);
			msr_wr(m);
			`CHK(o_fp_exc_enabled, |k[1:0])
			`CHK(o_fp_precise, |k[1:0])
			fire(6'h01, 3'h0, |k[1:0], cpu_ctl_pkg::CAUSE_FP, m);
		end
		spr(1'b0, 1'b1, `SPR_SAVE_RESTORE_2ND, 32'h0);
		`CHK(rd, m)
		spr(1'b0, 1'b0, `SPR_SAVE_RESTORE_2ND, 32'h0);
		`CHK(prv, 1'b1)
		wait_exc(1'b1, cpu_ctl_pkg::CAUSE_SPR_ILL, m);
		spr(1'b1, 1'b1, `SPR_TB_LOW_RD, 32'h0);
		`CHK(ill, 1'b1)
		wait_exc(1'b1, cpu_ctl_pkg::CAUSE_SPR_ILL, m);
		for (int k = 0; k < 8; k++) begin
			i_hard_reset_input_n = !k[2];
			m = {4'h0, k[1], 1'b0, k[0], 25'h0};
			spr(1'b1, 1'b1, `SPR_IMPL_CTL_ZERO, m);
			spr(1'b0, 1'b1, `SPR_IMPL_CTL_ZERO, 32'h0);
			`CHK(rd & 32'hBA00_0000, m)
			repeat (5) step();
			`CHK(o_clkout_oe, k[2] | k[1] | k[0])
			`CHK(o_clkout_bus_type, k[1] & !k[2])
		end
		i_hard_reset_input_n = 1'b1;
		spr(1'b1, 1'b1, `SPR_IMPL_CTL_ZERO, 32'h0);
		msr_wr(32'h0000_1000);
		for (int k = 0; k < 3; k++) begin
			fire(6'h0, 3'h4 >> k, 1'b0, cpu_ctl_pkg::CAUSE_NONE, 32'h0000_1000);
		end
		spr(1'b1, 1'b1, `SPR_IMPL_CTL_ZERO, 32'hB000_0000);
		for (int k = 0; k < 3; k++) begin
			fire(6'h0, 3'h4 >> k, 1'b1, cpu_ctl_pkg::CAUSE_MCHK, 32'h0000_1000);
		end
		msr_wr(32'h0);
		fire(6'h0, 3'h1, 1'b0, cpu_ctl_pkg::CAUSE_NONE, 32'h0);
		`CHK(o_checkstop, 1'b1)
		i_arst_n = 1'b0;
		step();
		`CHK(o_checkstop, 1'b0)
		`CHK(o_exc_cause, cpu_ctl_pkg::CAUSE_NONE)
		i_arst_n = 1'b1;
		repeat (3) step();
		for (int k = 0; k < 8; k++) begin
			i_addr_bus = (k == 0) ? 32'h0 : $random(seed);
			i_data_bus = {$random(seed), $random(seed)};
			step();
			e = par8({32'h0, i_addr_bus});
			`CHK(o_addr_par, e[3:0])
			`CHK(o_data_par, par8(i_data_bus))
		end
		end_of_test();
	end
endmodule
`default_nettype wire

// ### src/cpu_control_time_base_regs.sv
// control registers, exception gating and time base for the core
`timescale 1ns/10ps
`default_nettype none
`include "cpu_ctl_cfg.svh"
module cpu_control_time_base_regs #(
	parameter int AW = `ADDR_BUS_W,
	parameter int DW = `DATA_BUS_W
) (
	// clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_arst_n,
	// special register move port
	input  wire cpu_ctl_pkg::spr_req_t  i_spr_req,
	output logic                        o_spr_ack,
	output logic [31:0]                 o_spr_rdata,
	output logic                        o_spr_illegal,
	output logic                        o_spr_priv_fault,
	// machine state write port
	input  wire logic                   i_msr_we,
	input  wire logic [31:0]            i_msr_wdata,
	output logic [31:0]                 o_msr,
	// exception events, same clock
	input  wire cpu_ctl_pkg::exc_events_t i_events,
	input  wire logic                   i_tb_tick,
	input  wire logic                   i_handler_done,
	// pins
	input  wire logic                   i_machine_check_input_n,
	input  wire logic                   i_hard_reset_input_n,
	input  wire logic                   i_addr_par_err,
	input  wire logic                   i_data_par_err,
	// exception outputs
	output logic                        o_exc_take,
	output cpu_ctl_pkg::exc_cause_t     o_exc_cause,
	output logic                        o_handler_start,
	output logic [31:0]                 o_save_restore_second,
	output logic                        o_checkstop,
	output logic                        o_fp_exc_enabled,
	output logic                        o_fp_precise,
	// bus parity generation
	input  wire logic [AW-1:0]          i_addr_bus,
	input  wire logic [DW-1:0]          i_data_bus,
	output logic [AW/8-1:0]             o_addr_par,
	output logic [DW/8-1:0]             o_data_par,
	// clock out pin control
	output logic                        o_clkout_oe,
	output logic                        o_clkout_bus_type
);
	// ****************************************
	// reset release and pin synchronisers
	// ****************************************
	logic rst_meta_ff, rst_n_ff;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff    <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff    <= rst_meta_ff;
		end
	end

	logic [1:0] pins_sync;
	pin_sync #(
		.W    (2),
		.INIT (2'b11)
	) u_pin_sync (
		.i_clk   (i_clk),
		.i_rst_n (rst_n_ff),
		.i_async ({i_machine_check_input_n, i_hard_reset_input_n}),
		.o_sync  (pins_sync)
	);
	logic mcp_active, hard_reset_active;
	assign mcp_active        = ~pins_sync[1];
	assign hard_reset_active = ~pins_sync[0];
	// ****************************************
	// register state
	// ****************************************
	logic [31:0]              msr_ff, nxt_msr;
	logic [31:0]              icz_ff, nxt_icz;
	logic [31:0]              srr2_ff, nxt_srr2;
	logic [31:0]              rdata_ff, nxt_rdata;
	logic                     ack_ff, nxt_ack;
	logic                     ill_ff, nxt_ill;
	logic                     priv_ff, nxt_priv;
	cpu_ctl_pkg::core_state_t state_ff, nxt_state;
	cpu_ctl_pkg::exc_cause_t  cause_ff, nxt_cause;
	logic                     take_ff, nxt_take;
	logic                     start_ff, nxt_start;
	logic [31:0]              tb_high, tb_low;
	logic                     tb_wr_high, tb_wr_low;
	// ****************************************
	// field decode
	// ****************************************
	logic ext_en, mchk_en, fp_mode_a, fp_mode_b;
	assign ext_en    = msr_ff[`MSR_EXT_IRQ_EN_POS];
	assign mchk_en   = msr_ff[`MSR_MCHK_EN_POS];
	assign fp_mode_a = msr_ff[`MSR_FP_MODE_A_POS];
	assign fp_mode_b = msr_ff[`MSR_FP_MODE_B_POS];
	// imprecise encodings are run as precise
	logic fp_enabled;
	assign fp_enabled = fp_mode_a | fp_mode_b;
	logic check_pin_en, addr_par_check_en, data_par_check_en, clk_type_bit, clkout_enable_bit;
	assign check_pin_en      = icz_ff[`ICZ_CHECK_PIN_EN_POS];
	assign addr_par_check_en = icz_ff[`ICZ_ADDR_PAR_EN_POS];
	assign data_par_check_en = icz_ff[`ICZ_DATA_PAR_EN_POS];
	assign clk_type_bit      = icz_ff[`ICZ_CLK_TYPE_POS];
	assign clkout_enable_bit = icz_ff[`ICZ_CLKOUT_EN_POS];
	// ****************************************
	// special register access decode
	// ****************************************
	logic rd, wr, sup;
	assign rd  = i_spr_req.valid & ~i_spr_req.write;
	assign wr  = i_spr_req.valid & i_spr_req.write;
	assign sup = i_spr_req.supervisor;
	always_comb begin
		nxt_ack    = i_spr_req.valid;
		nxt_rdata  = 32'h0000_0000;
		nxt_ill    = 1'b0;
		nxt_priv   = 1'b0;
		tb_wr_high = 1'b0;
		tb_wr_low  = 1'b0;
		nxt_icz    = icz_ff;
		case (i_spr_req.num)
			`SPR_TB_HIGH_RD: begin
				nxt_rdata = rd ? tb_high : 32'h0000_0000;
				nxt_ill   = wr;
			end
			`SPR_TB_LOW_RD: begin
				nxt_rdata = rd ? tb_low : 32'h0000_0000;
				nxt_ill   = wr;
			end
			`SPR_TB_HIGH_WR: begin
				nxt_ill    = rd;
				nxt_priv   = wr & ~sup;
				tb_wr_high = wr & sup;
			end
			`SPR_TB_LOW_WR: begin
				nxt_ill   = rd;
				nxt_priv  = wr & ~sup;
				tb_wr_low = wr & sup;
			end
			`SPR_IMPL_CTL_ZERO: begin
				nxt_priv  = i_spr_req.valid & ~sup;
				nxt_rdata = (rd & sup) ? icz_ff : 32'h0000_0000;
				if (wr & sup) begin
					nxt_icz = i_spr_req.wdata;
				end
			end
			`SPR_SAVE_RESTORE_2ND: begin
				nxt_priv = i_spr_req.valid & ~sup;
				nxt_rdata = (rd & sup) ? srr2_ff : 32'h0000_0000;
			end
			default: begin
				nxt_ill = i_spr_req.valid;
			end
		endcase
	end
	time_base_counter #(
		.HALF_W (32)
	) u_time_base (
		.i_clk     (i_clk),
		.i_rst_n   (rst_n_ff),
		.i_tick    (i_tb_tick),
		.i_wr_high (tb_wr_high),
		.i_wr_low  (tb_wr_low),
		.i_wdata   (i_spr_req.wdata),
		.o_high    (tb_high),
		.o_low     (tb_low)
	);
	// ****************************************
	// exception gating and entry
	// ****************************************
	logic mchk_event, ext_event, fp_event, spr_trap;
	assign mchk_event = (check_pin_en & mcp_active)
		| (addr_par_check_en & i_addr_par_err)
		| (data_par_check_en & i_data_par_err);
	assign ext_event  = ext_en & (i_events.ext_irq | i_events.decrementer
		| i_events.sys_mgmt | i_events.perf_mon | i_events.thermal);
	assign fp_event   = fp_enabled & i_events.fp_exc;
	assign spr_trap   = ack_ff & (ill_ff | priv_ff);
	always_comb begin
		nxt_state = state_ff;
		nxt_cause = cpu_ctl_pkg::CAUSE_NONE;
		nxt_take  = 1'b0;
		nxt_start = take_ff;
		nxt_srr2  = srr2_ff;
		nxt_msr   = msr_ff;
		if (i_msr_we) begin
			nxt_msr = i_msr_wdata;
		end
		case (state_ff)
			cpu_ctl_pkg::RUN_ST: begin
				// machine check outranks everything, checkstop when it is masked
				if (mchk_event && !mchk_en) begin
					nxt_state = cpu_ctl_pkg::CHECKSTOP_ST;
				end else if (mchk_event || spr_trap || fp_event || ext_event) begin
					nxt_take  = 1'b1;
					nxt_state = cpu_ctl_pkg::HANDLER_ST;
					nxt_srr2  = msr_ff;
					nxt_msr[`MSR_EXT_IRQ_EN_POS] = 1'b0;
					if (mchk_event) begin
						nxt_cause = cpu_ctl_pkg::CAUSE_MCHK;
						nxt_msr[`MSR_MCHK_EN_POS] = 1'b0;
					end else if (spr_trap) begin
						nxt_cause = cpu_ctl_pkg::CAUSE_SPR_ILL;
					end else if (fp_event) begin
						nxt_cause = cpu_ctl_pkg::CAUSE_FP;
					end else begin
						nxt_cause = cpu_ctl_pkg::CAUSE_EXTERNAL;
					end
				end
			end
			cpu_ctl_pkg::HANDLER_ST: begin
				if (mchk_event && !mchk_en) begin
					nxt_state = cpu_ctl_pkg::CHECKSTOP_ST;
				end else if (i_handler_done) begin
					nxt_state = cpu_ctl_pkg::RUN_ST;
				end
			end
			cpu_ctl_pkg::CHECKSTOP_ST: nxt_state = cpu_ctl_pkg::CHECKSTOP_ST;
			default:                   nxt_state = cpu_ctl_pkg::RUN_ST;
		endcase
	end
	always_ff @(posedge i_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			msr_ff   <= `MSR_RESET;
			icz_ff   <= `ICZ_RESET;
			srr2_ff  <= 32'h0000_0000;
			rdata_ff <= 32'h0000_0000;
			ack_ff   <= 1'b0;
			ill_ff   <= 1'b0;
			priv_ff  <= 1'b0;
			state_ff <= cpu_ctl_pkg::RUN_ST;
			cause_ff <= cpu_ctl_pkg::CAUSE_NONE;
			take_ff  <= 1'b0;
			start_ff <= 1'b0;
		end else begin
			msr_ff   <= nxt_msr;
			icz_ff   <= nxt_icz;
			srr2_ff  <= nxt_srr2;
			rdata_ff <= nxt_rdata;
			ack_ff   <= nxt_ack;
			ill_ff   <= nxt_ill;
			priv_ff  <= nxt_priv;
			state_ff <= nxt_state;
			cause_ff <= nxt_cause;
			take_ff  <= nxt_take;
			start_ff <= nxt_start;
		end
	end
	// ****************************************
	// bus parity, independent of check enables
	// ****************************************
	logic [AW/8-1:0] nxt_addr_par, addr_par_ff;
	logic [DW/8-1:0] nxt_data_par, data_par_ff;
	genvar gi;
	generate
		for (gi = 0; gi < DW/8; gi++) begin : g_par
			assign nxt_data_par[gi] = ~^i_data_bus[gi*8 +: 8];
			if (gi < AW/8) begin : g_addr
				assign nxt_addr_par[gi] = ~^i_addr_bus[gi*8 +: 8];
			end
		end
	endgenerate
	always_ff @(posedge i_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			addr_par_ff <= '0;
			data_par_ff <= '0;
		end else begin
			addr_par_ff <= nxt_addr_par;
			data_par_ff <= nxt_data_par;
		end
	end
	// ****************************************
	// clock out pin
	// ****************************************
	// pin driven during hard reset so the board sees a clock early
	logic nxt_clkout_oe, nxt_clkout_type;
	logic clkout_oe_ff, clkout_type_ff;
	always_comb begin
		nxt_clkout_oe   = hard_reset_active | clkout_enable_bit | clk_type_bit;
		nxt_clkout_type = ~hard_reset_active & clk_type_bit;
	end
	always_ff @(posedge i_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			clkout_oe_ff   <= 1'b0;
			clkout_type_ff <= 1'b0;
		end else begin
			clkout_oe_ff   <= nxt_clkout_oe;
			clkout_type_ff <= nxt_clkout_type;
		end
	end
	// ****************************************
	// outputs
	// ****************************************
	assign o_spr_ack             = ack_ff;
	assign o_spr_rdata           = rdata_ff;
	assign o_spr_illegal         = ack_ff & ill_ff;
	assign o_spr_priv_fault      = ack_ff & priv_ff;
	assign o_msr                 = msr_ff;
	assign o_exc_take            = take_ff;
	assign o_exc_cause           = cause_ff;
	assign o_handler_start       = start_ff;
	assign o_save_restore_second = srr2_ff;
	assign o_checkstop           = (state_ff == cpu_ctl_pkg::CHECKSTOP_ST);
	assign o_fp_exc_enabled      = fp_enabled;
	assign o_fp_precise          = fp_enabled;
	assign o_addr_par            = addr_par_ff;
	assign o_data_par            = data_par_ff;
	assign o_clkout_oe           = clkout_oe_ff;
	assign o_clkout_bus_type     = clkout_type_ff;
endmodule
`default_nettype wire

// ### src/cpu_ctl_cfg.svh
// constants: register numbers, field positions, reset values for the control block
`ifndef CPU_CTL_CFG_SVH
`define CPU_CTL_CFG_SVH

// ****************************************
// special register numbers
// ****************************************
`define SPR_NUM_W            10
`define SPR_TB_HIGH_RD       10'h10C
`define SPR_TB_LOW_RD        10'h10D
`define SPR_TB_HIGH_WR       10'h11C
`define SPR_TB_LOW_WR        10'h11D
`define SPR_IMPL_CTL_ZERO    10'h3F0
`define SPR_SAVE_RESTORE_2ND 10'h01B

// ****************************************
// machine state field positions (lsb index = 31 - printed bit)
// ****************************************
`define MSR_EXT_IRQ_EN_POS   15
`define MSR_MCHK_EN_POS      12
`define MSR_FP_MODE_A_POS    11
`define MSR_FP_MODE_B_POS    8
`define MSR_RESET            32'h0000_0000

// ****************************************
// control register zero field positions
// ****************************************
`define ICZ_CHECK_PIN_EN_POS 31
`define ICZ_ADDR_PAR_EN_POS  29
`define ICZ_DATA_PAR_EN_POS  28
`define ICZ_CLK_TYPE_POS     27
`define ICZ_CLKOUT_EN_POS    25
`define ICZ_RESET            32'h0000_0000

// ****************************************
// widths
// ****************************************
`define ADDR_BUS_W           32
`define DATA_BUS_W           64

`endif

// ### src/cpu_ctl_pkg.sv
// types shared by the control and time base block
package cpu_ctl_pkg;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        supervisor;
		logic [9:0]  num;
		logic [31:0] wdata;
	} spr_req_t;

	typedef struct packed {
		logic ext_irq;
		logic decrementer;
		logic sys_mgmt;
		logic perf_mon;
		logic thermal;
		logic fp_exc;
	} exc_events_t;

	typedef enum logic [4:0] {
		CAUSE_NONE     = 5'b00001,
		CAUSE_MCHK     = 5'b00010,
		CAUSE_FP       = 5'b00100,
		CAUSE_EXTERNAL = 5'b01000,
		CAUSE_SPR_ILL  = 5'b10000
	} exc_cause_t;

	typedef enum logic [2:0] {
		RUN_ST       = 3'b001,
		HANDLER_ST   = 3'b010,
		CHECKSTOP_ST = 3'b100
	} core_state_t;

endpackage

// ### src/pin_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	// pins
	input  wire logic [W-1:0] i_async,
	// synchronised
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_ff <= INIT;
			sync_ff <= INIT;
		end else begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
		end
	end

	assign o_sync = sync_ff;
endmodule
`default_nettype wire

// ### src/time_base_counter.sv
// 64-bit time base built from two 32-bit halves
`timescale 1ns/10ps
`default_nettype none
module time_base_counter #(
	parameter int HALF_W = 32
) (
	// clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	// count enable
	input  wire logic              i_tick,
	// half writes
	input  wire logic              i_wr_high,
	input  wire logic              i_wr_low,
	input  wire logic [HALF_W-1:0] i_wdata,
	// count
	output logic      [HALF_W-1:0] o_high,
	output logic      [HALF_W-1:0] o_low
);
	logic [HALF_W-1:0] high_ff;
	logic [HALF_W-1:0] low_ff;
	logic [HALF_W-1:0] nxt_high;
	logic [HALF_W-1:0] nxt_low;
	logic [2*HALF_W-1:0] sum;

	always_comb begin
		sum      = {high_ff, low_ff} + {{(2*HALF_W-1){1'b0}}, i_tick};
		nxt_high = sum[2*HALF_W-1:HALF_W];
		nxt_low  = sum[HALF_W-1:0];
		// a write to one half leaves the other counting
		if (i_wr_high) begin
			nxt_high = i_wdata;
		end
		if (i_wr_low) begin
			nxt_low = i_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			high_ff <= '0;
			low_ff  <= '0;
		end else begin
			high_ff <= nxt_high;
			low_ff  <= nxt_low;
		end
	end

	assign o_high = high_ff;
	assign o_low  = low_ff;
endmodule
`default_nettype wire
